/* design/dpr_consts.svh */
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define DPR_DATA_W 18
`define DPR_ADDR_W 19
`define DPR_BE_W 2
`define DPR_LANE_W 9

// ----------------------------------------
// Timing
// ----------------------------------------
`define DPR_CLK_MHZ 10
`define DPR_CLK_PERIOD_NS 100
`define DPR_SLOW_LIMIT_MHZ 100
`define DPR_RST_PULSE_NS 1000
`define DPR_RST_PULSE_CYC ((`DPR_RST_PULSE_NS + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)

// ----------------------------------------
// Port indices
// ----------------------------------------
`define DPR_PORT_LEFT 0
`define DPR_PORT_RIGHT 1

`endif

/* design/dpr_pkg.sv */
`include "dpr_consts.svh"

package dpr_pkg;

   // ----------------------------------------
   // Host command codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      DPR_OP_NOP        = 3'h0,
      DPR_OP_READ       = 3'h1,
      DPR_OP_WRITE      = 3'h2,
      DPR_OP_READ_NEXT  = 3'h3,
      DPR_OP_WRITE_NEXT = 3'h4,
      DPR_OP_CNT_RESET  = 3'h5,
      DPR_OP_MASK_LOAD  = 3'h6,
      DPR_OP_MASK_RESET = 3'h7
   } dpr_op_t;

   // ----------------------------------------
   // Host sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      DPR_HS_RESET = 2'h1,
      DPR_HS_RUN   = 2'h2
   } dpr_host_state_t;

endpackage

/* design/dpr_if.sv */
`timescale 1ns/1ns
`include "dpr_consts.svh"

interface dpr_if #(
   parameter int AW = `DPR_ADDR_W,
   parameter int DW = `DPR_DATA_W
);
   // Index 0 is the left port, index 1 the right port
   logic global_reset_n;
   logic [1:0][AW-1:0] addr;
   logic [1:0] rw_n;
   logic [1:0] ce_n;
   logic [1:0] oe_n;
   logic [1:0][`DPR_BE_W-1:0] byte_lane_enable_n;
   logic [1:0] cnt_msk;
   logic [1:0] cntrst_n;
   logic [1:0] ads_n;
   logic [1:0] cnten_n;
   logic [1:0] wrap_mode_select;
   logic [1:0] slow_clock_select;
   logic [1:0][DW-1:0] dq_host_o;
   logic [1:0] dq_host_oe;
   logic [1:0][DW-1:0] dq_dev_o;
   logic [1:0] dq_dev_oe;
   logic [1:0][DW-1:0] dq;
   logic [1:0] mailbox_flag_n;
   logic [1:0] counter_wrap_flag_n;
   logic [1:0] ready;
   logic [1:0] align_loop_en;

   // ----------------------------------------
   // Shared data pins; undriven reads as zero
   // ----------------------------------------
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         if (dq_dev_oe[p]) begin
            dq[p] = dq_dev_o[p];
         end else if (dq_host_oe[p]) begin
            dq[p] = dq_host_o[p];
         end else begin
            dq[p] = '0;
         end
      end
   end

   modport dev (
      input global_reset_n, addr, rw_n, ce_n, oe_n, byte_lane_enable_n, cnt_msk, cntrst_n,
      input ads_n, cnten_n, wrap_mode_select, slow_clock_select, dq,
      output dq_dev_o, dq_dev_oe, mailbox_flag_n, counter_wrap_flag_n, ready, align_loop_en
   );

   modport host (
      output global_reset_n, addr, rw_n, ce_n, oe_n, byte_lane_enable_n, cnt_msk, cntrst_n,
      output ads_n, cnten_n, wrap_mode_select, slow_clock_select, dq_host_o, dq_host_oe,
      input dq, dq_dev_oe, mailbox_flag_n, counter_wrap_flag_n, ready, align_loop_en
   );

endinterface

/* design/dpr_host.sv */
`timescale 1ns/1ns
`include "dpr_consts.svh"

module dpr_host
   import dpr_pkg::*;
#(
   parameter int AW = `DPR_ADDR_W,
   parameter int DW = `DPR_DATA_W,
   parameter int RST_CYC = `DPR_RST_PULSE_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   dpr_if.host link,
   input wire logic [1:0] i_cmd_valid,
   input wire dpr_op_t [1:0] i_cmd_op,
   input wire logic [1:0][AW-1:0] i_cmd_addr,
   input wire logic [1:0][DW-1:0] i_cmd_wdata,
   input wire logic [1:0][`DPR_BE_W-1:0] i_cmd_be,
   input wire logic [1:0] i_wrap_mode,
   output logic o_cmd_ready,
   output logic [1:0] o_rd_valid,
   output logic [1:0][DW-1:0] o_rd_data,
   output logic [1:0] o_mbx_flag_n,
   output logic [1:0] o_wrap_flag_n
);

   localparam int CW = $clog2(RST_CYC + 1);
   localparam logic SLOW = (`DPR_CLK_MHZ < `DPR_SLOW_LIMIT_MHZ);

   dpr_host_state_t state_r;
   logic [CW-1:0] rst_cnt_r;
   logic grst_n_r;
   logic [1:0] rw_n_r, ce_n_r, oe_n_r, cnt_msk_r, cntrst_n_r, ads_n_r, cnten_n_r, wrap_r, slow_r;
   logic [1:0][AW-1:0] addr_r;
   logic [1:0][`DPR_BE_W-1:0] be_n_r;
   logic [1:0][DW-1:0] wdata_r;
   logic [1:0] wdata_oe_r;
   logic cmd_ready_r;

   // ----------------------------------------
   // Power-up global reset pulse
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r <= DPR_HS_RESET;
         rst_cnt_r <= '0;
         grst_n_r <= 1'b0;
         cmd_ready_r <= 1'b0;
      end else begin
         unique case (state_r)
            DPR_HS_RESET: begin
               grst_n_r <= 1'b0;
               rst_cnt_r <= rst_cnt_r + CW'(1);
               if (rst_cnt_r == CW'(RST_CYC - 1)) begin
                  state_r <= DPR_HS_RUN;
                  grst_n_r <= 1'b1;
               end
            end
            DPR_HS_RUN: begin
               cmd_ready_r <= &link.ready;
            end
            // Two-bit one-hot leaves illegal codes; fall back to the reset pulse
            default: begin
               state_r <= DPR_HS_RESET;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Pin drive, one command per port per cycle
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      for (int p = 0; p < 2; p++) begin
         ce_n_r[p] <= 1'b1;
         rw_n_r[p] <= 1'b1;
         oe_n_r[p] <= 1'b1;
         cnt_msk_r[p] <= 1'b1;
         cntrst_n_r[p] <= 1'b1;
         ads_n_r[p] <= 1'b1;
         cnten_n_r[p] <= 1'b1;
         be_n_r[p] <= '1;
         wdata_oe_r[p] <= 1'b0;
         wrap_r[p] <= i_wrap_mode[p];
         slow_r[p] <= SLOW;
         addr_r[p] <= i_cmd_addr[p];
         wdata_r[p] <= i_cmd_wdata[p];
         if (!i_rst && cmd_ready_r && i_cmd_valid[p]) begin
            unique case (i_cmd_op[p])
               DPR_OP_NOP: begin
               end
               DPR_OP_READ, DPR_OP_READ_NEXT: begin
                  ce_n_r[p] <= 1'b0;
                  rw_n_r[p] <= 1'b1;
                  oe_n_r[p] <= 1'b0;
                  be_n_r[p] <= ~i_cmd_be[p];
                  ads_n_r[p] <= (i_cmd_op[p] == DPR_OP_READ_NEXT);
                  cnten_n_r[p] <= 1'b0;
               end
               DPR_OP_WRITE, DPR_OP_WRITE_NEXT: begin
                  ce_n_r[p] <= 1'b0;
                  rw_n_r[p] <= 1'b0;
                  be_n_r[p] <= ~i_cmd_be[p];
                  wdata_oe_r[p] <= 1'b1;
                  ads_n_r[p] <= (i_cmd_op[p] == DPR_OP_WRITE_NEXT);
                  cnten_n_r[p] <= 1'b0;
               end
               DPR_OP_CNT_RESET: begin
                  cntrst_n_r[p] <= 1'b0;
               end
               DPR_OP_MASK_LOAD: begin
                  cnt_msk_r[p] <= 1'b0;
                  ads_n_r[p] <= 1'b0;
                  cnten_n_r[p] <= 1'b0;
               end
               DPR_OP_MASK_RESET: begin
                  cnt_msk_r[p] <= 1'b0;
                  cntrst_n_r[p] <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Returned data and flags
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_rd_valid <= '0;
         o_rd_data <= '0;
         o_mbx_flag_n <= '1;
         o_wrap_flag_n <= '1;
      end else begin
         o_rd_valid <= link.dq_dev_oe;
         for (int p = 0; p < 2; p++) begin
            if (link.dq_dev_oe[p]) begin
               o_rd_data[p] <= link.dq[p];
            end
         end
         o_mbx_flag_n <= link.mailbox_flag_n;
         o_wrap_flag_n <= link.counter_wrap_flag_n;
      end
   end

   assign o_cmd_ready = cmd_ready_r;
   assign link.global_reset_n = grst_n_r;
   assign link.addr = addr_r;
   assign link.rw_n = rw_n_r;
   assign link.ce_n = ce_n_r;
   assign link.oe_n = oe_n_r;
   assign link.byte_lane_enable_n = be_n_r;
   assign link.cnt_msk = cnt_msk_r;
   assign link.cntrst_n = cntrst_n_r;
   assign link.ads_n = ads_n_r;
   assign link.cnten_n = cnten_n_r;
   assign link.wrap_mode_select = wrap_r;
   assign link.slow_clock_select = slow_r;
   assign link.dq_host_o = wdata_r;
   assign link.dq_host_oe = wdata_oe_r;

endmodule // dpr_host

/* design/dpr_dev.sv */
`timescale 1ns/1ns
`include "dpr_consts.svh"

module dpr_dev
   import dpr_pkg::*;
#(
   parameter int AW = `DPR_ADDR_W,
   parameter int DW = `DPR_DATA_W
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   dpr_if.dev link,
   output logic [1:0][AW-1:0] o_cnt_value,
   output logic [1:0][AW-1:0] o_mask_value
);

   localparam int LW = `DPR_LANE_W;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Mailbox word owned by a port
   function automatic logic [AW-1:0] mbx_addr(input int port);
      mbx_addr = (port == `DPR_PORT_RIGHT) ? {AW{1'b1}} : {{(AW-1){1'b1}}, 1'b0};
   endfunction

   function automatic logic any_lane(input logic [`DPR_BE_W-1:0] be_n);
      any_lane = (be_n != {`DPR_BE_W{1'b1}});
   endfunction

   // Global reset from the host is on this clock, so no synchroniser
   logic rst_all;
   assign rst_all = i_rst | ~link.global_reset_n;

   logic [DW-1:0] mem [2**AW];
   logic [1:0][AW-1:0] acc_addr;
   logic [1:0] wr_go;
   logic [1:0] rd_go;
   logic [1:0] mbx_set;
   logic [1:0] mbx_clr;
   logic [1:0] mbx_flag_n_r;
   logic [1:0][DW-1:0] dq_out_r;
   logic [1:0] dq_oe_r;
   logic [1:0] ready_r;
   logic [1:0] align_en_r;

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         acc_addr[p] = link.ads_n[p] ? o_cnt_value[p] : link.addr[p];
         wr_go[p] = ~link.ce_n[p] & ~link.rw_n[p] & any_lane(link.byte_lane_enable_n[p]);
         rd_go[p] = ~link.ce_n[p] & link.rw_n[p];
      end
   end

   // ----------------------------------------
   // Storage; mailbox words store data too
   // ----------------------------------------
   // Same word written by both ports is undefined; right lands last here
   always_ff @(posedge i_clk_sys) begin
      for (int p = 0; p < 2; p++) begin
         for (int b = 0; b < `DPR_BE_W; b++) begin
            if (wr_go[p] && !link.byte_lane_enable_n[p][b]) begin
               mem[acc_addr[p]][b*LW +: LW] <= link.dq[p][b*LW +: LW];
            end
         end
      end
   end

   // ----------------------------------------
   // Read data and pin drive
   // ----------------------------------------
   // Output enable is sampled with the read, so drive and data both appear one clock later
   always_ff @(posedge i_clk_sys) begin
      for (int p = 0; p < 2; p++) begin
         dq_out_r[p] <= mem[acc_addr[p]];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (rst_all) begin
         dq_oe_r <= '0;
      end else begin
         dq_oe_r <= rd_go & ~link.oe_n;
      end
   end

   // ----------------------------------------
   // Mailbox flags
   // ----------------------------------------
   always_comb begin
      for (int q = 0; q < 2; q++) begin
         mbx_set[q] = wr_go[1-q] && (acc_addr[1-q] == mbx_addr(q));
         mbx_clr[q] = rd_go[q] && any_lane(link.byte_lane_enable_n[q]) &&
                      (acc_addr[q] == mbx_addr(q));
      end
   end

   always_ff @(posedge i_clk_sys) begin
      for (int q = 0; q < 2; q++) begin
         if (rst_all) begin
            mbx_flag_n_r[q] <= 1'b1;
         end else if (mbx_set[q]) begin
            mbx_flag_n_r[q] <= 1'b0;
         end else if (mbx_clr[q]) begin
            mbx_flag_n_r[q] <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Per-port burst counters
   // ----------------------------------------
   genvar gp;
   generate
      for (gp = 0; gp < 2; gp++) begin : g_port
         logic [AW-1:0] cnt_r, cnt_nxt;
         logic [AW-1:0] mask_r, mask_nxt;
         logic [AW-1:0] mirror_r, mirror_nxt;
         logic wrap_flag_n_r, wrap_flag_n_nxt;
         logic [AW-1:0] inc_val;
         logic at_max;

         always_comb begin
            inc_val = (((cnt_r | ~mask_r) + {{(AW-1){1'b0}}, 1'b1}) & mask_r) | (cnt_r & ~mask_r);
            at_max = ((cnt_r & mask_r) == mask_r);
            cnt_nxt = cnt_r;
            mask_nxt = mask_r;
            mirror_nxt = mirror_r;
            wrap_flag_n_nxt = wrap_flag_n_r;
            if (link.cnt_msk[gp]) begin
               if (!link.cntrst_n[gp]) begin
                  cnt_nxt = cnt_r & ~mask_r;
                  mirror_nxt = cnt_r & ~mask_r;
                  wrap_flag_n_nxt = 1'b1;
               end else if (!link.ads_n[gp] && !link.cnten_n[gp]) begin
                  cnt_nxt = link.addr[gp];
                  mirror_nxt = link.addr[gp];
                  wrap_flag_n_nxt = 1'b1;
               end else if (link.ads_n[gp] && !link.cnten_n[gp]) begin
                  if (at_max) begin
                     if (link.wrap_mode_select[gp]) begin
                        cnt_nxt = mirror_r;
                     end else begin
                        cnt_nxt = cnt_r & ~mask_r;
                     end
                  end else begin
                     cnt_nxt = inc_val;
                  end
                  wrap_flag_n_nxt = ~((cnt_nxt & mask_r) == mask_r);
               end
            end else begin
               if (!link.cntrst_n[gp]) begin
                  mask_nxt = '1;
               end else if (!link.ads_n[gp] && !link.cnten_n[gp]) begin
                  mask_nxt = link.addr[gp];
               end
            end
         end

         // Single clock today; each port keeps its own state and control
         always_ff @(posedge i_clk_sys) begin
            if (rst_all) begin
               cnt_r <= '0;
               mask_r <= '1;
               mirror_r <= '0;
               wrap_flag_n_r <= 1'b1;
            end else begin
               cnt_r <= cnt_nxt;
               mask_r <= mask_nxt;
               mirror_r <= mirror_nxt;
               wrap_flag_n_r <= wrap_flag_n_nxt;
            end
         end

         assign o_cnt_value[gp] = cnt_r;
         assign o_mask_value[gp] = mask_r;
         assign link.counter_wrap_flag_n[gp] = wrap_flag_n_r;
      end
   endgenerate

   // ----------------------------------------
   // Ready and clock alignment loop
   // ----------------------------------------
   // No real alignment loop here; the enable only shows its state
   always_ff @(posedge i_clk_sys) begin
      if (rst_all) begin
         ready_r <= '0;
         align_en_r <= '0;
      end else begin
         ready_r <= '1;
         align_en_r <= ~link.slow_clock_select;
      end
   end

   assign link.dq_dev_o = dq_out_r;
   assign link.dq_dev_oe = dq_oe_r;
   assign link.mailbox_flag_n = mbx_flag_n_r;
   assign link.ready = ready_r;
   assign link.align_loop_en = align_en_r;

endmodule // dpr_dev

/* testbench/dpr_props.sv */
`timescale 1ns/1ns

module dpr_props #(
   parameter int AW = 19
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic global_reset_n,
   input wire logic [1:0][AW-1:0] addr,
   input wire logic [1:0] rw_n,
   input wire logic [1:0] ce_n,
   input wire logic [1:0] oe_n,
   input wire logic [1:0][1:0] byte_lane_enable_n,
   input wire logic [1:0] cnt_msk,
   input wire logic [1:0] cntrst_n,
   input wire logic [1:0] ads_n,
   input wire logic [1:0] cnten_n,
   input wire logic [1:0] slow_clock_select,
   input wire logic [1:0] dq_host_oe,
   input wire logic [1:0] dq_dev_oe,
   input wire logic [1:0] mailbox_flag_n,
   input wire logic [1:0] counter_wrap_flag_n,
   input wire logic [1:0] ready,
   input wire logic [1:0] align_loop_en
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // ----------------------------------------
   // Mailbox events
   // ----------------------------------------
   // Only direct-address accesses count; counter-addressed ones, which the device also decodes against the mailboxes, are not modelled
   logic [1:0][AW-1:0] mbx;
   logic [1:0] acc;
   logic [1:0] set_ev;
   logic [1:0] clr_ev;
   assign mbx[1] = '1;
   assign mbx[0] = {{(AW-1){1'b1}}, 1'b0};
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         acc[p] = global_reset_n & ~ce_n[p] & ~ads_n[p] & ~&byte_lane_enable_n[p];
      end
      for (int p = 0; p < 2; p++) begin
         set_ev[p] = acc[1-p] & ~rw_n[1-p] & (addr[1-p] == mbx[p]);
         clr_ev[p] = acc[p] & rw_n[p] & (addr[p] == mbx[p]);
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_read_drive;
      dq_dev_oe == $past(~ce_n & rw_n & ~oe_n & {2{global_reset_n}});
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("data drive without read");
   property p_no_clash;
      (dq_host_oe & dq_dev_oe) == 2'h0;
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
   property p_host_write;
      (dq_host_oe & (ce_n | rw_n)) == 2'h0;
   endproperty
   a_host_write: assert property (p_host_write) else $error("host drives outside write");
   property p_reset_state;
      !global_reset_n |=> mailbox_flag_n == 2'h3 && counter_wrap_flag_n == 2'h3 && ready == 2'h0;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
   property p_ready;
      global_reset_n |=> ready == 2'h3;
   endproperty
   a_ready: assert property (p_ready) else $error("ready missing");
   property p_align;
      global_reset_n |=> align_loop_en == ~$past(slow_clock_select);
   endproperty
   a_align: assert property (p_align) else $error("align loop wrong");
   property p_rst_pulse;
      $rose(global_reset_n) |-> !$past(global_reset_n, 2);
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");

   for (genvar p = 0; p < 2; p++) begin : g_port
      property p_mbx_set;
         set_ev[p] |=> !mailbox_flag_n[p];
      endproperty
      a_mbx_set: assert property (p_mbx_set) else $error("mailbox flag not set");
      property p_mbx_clr;
         clr_ev[p] && !set_ev[p] |=> mailbox_flag_n[p];
      endproperty
      a_mbx_clr: assert property (p_mbx_clr) else $error("mailbox flag not cleared");
      property p_mbx_hold;
         global_reset_n && !set_ev[p] && !clr_ev[p] |=> $stable(mailbox_flag_n[p]);
      endproperty
      a_mbx_hold: assert property (p_mbx_hold) else $error("mailbox flag moved");
      property p_wrap_cause;
         $fell(counter_wrap_flag_n[p]) |-> $past(cnt_msk[p] & cntrst_n[p] & ads_n[p] & ~cnten_n[p]);
      endproperty
      a_wrap_cause: assert property (p_wrap_cause) else $error("wrap flag without increment");
   end

   c_mbx_set: cover property (set_ev[1] ##1 !mailbox_flag_n[1]);
   c_wrap: cover property ($fell(counter_wrap_flag_n[0]));
   c_read: cover property (dq_dev_oe[1]);
endmodule // dpr_props

/* testbench/tb_dual_port_ram_port_control.sv */
`timescale 1ns/1ns

module tb_dual_port_ram_port_control
   import dpr_pkg::*;
;
   localparam int AW = 6;
   localparam int DW = 18;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [1:0] cmd_valid = '0;
   dpr_op_t [1:0] cmd_op = '{DPR_OP_NOP, DPR_OP_NOP};
   logic [1:0][AW-1:0] cmd_addr = '0;
   logic [1:0][DW-1:0] cmd_wdata = '0;
   logic [1:0][1:0] cmd_be = '0;
   logic [1:0] wrap_mode = '0;
   logic cmd_ready;
   logic [1:0] rd_valid;
   logic [1:0] mbx_flag_n;
   logic [1:0] wrap_flag_n;
   logic [1:0][DW-1:0] rd_data;
   logic [1:0][AW-1:0] cnt_value;
   logic [1:0][AW-1:0] mask_value;
   logic [DW-1:0] shadow [64];
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;

   always #50 i_clk_sys = ~i_clk_sys;

   dpr_if #(.AW(AW), .DW(DW)) dpr_if_inst ();
   dpr_host #(.AW(AW), .DW(DW), .RST_CYC(2)) dpr_host_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .link(dpr_if_inst), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr),
      .i_cmd_wdata(cmd_wdata), .i_cmd_be(cmd_be), .i_wrap_mode(wrap_mode), .o_cmd_ready(cmd_ready),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_mbx_flag_n(mbx_flag_n), .o_wrap_flag_n(wrap_flag_n));
   dpr_dev #(.AW(AW), .DW(DW)) dpr_dev_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(dpr_if_inst),
      .o_cnt_value(cnt_value), .o_mask_value(mask_value));
   dpr_props #(.AW(AW)) dpr_props_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .global_reset_n(dpr_if_inst.global_reset_n), .addr(dpr_if_inst.addr), .rw_n(dpr_if_inst.rw_n),
      .ce_n(dpr_if_inst.ce_n), .oe_n(dpr_if_inst.oe_n), .byte_lane_enable_n(dpr_if_inst.byte_lane_enable_n),
      .cnt_msk(dpr_if_inst.cnt_msk), .cntrst_n(dpr_if_inst.cntrst_n), .ads_n(dpr_if_inst.ads_n),
      .cnten_n(dpr_if_inst.cnten_n), .slow_clock_select(dpr_if_inst.slow_clock_select),
      .dq_host_oe(dpr_if_inst.dq_host_oe), .dq_dev_oe(dpr_if_inst.dq_dev_oe),
      .mailbox_flag_n(dpr_if_inst.mailbox_flag_n), .counter_wrap_flag_n(dpr_if_inst.counter_wrap_flag_n),
      .ready(dpr_if_inst.ready), .align_loop_en(dpr_if_inst.align_loop_en));

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Extra idle cycle so valid never toggles twice in one step
   task automatic cmd(input int p, input dpr_op_t op, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input logic [1:0] be);
      logic [DW-1:0] m;
      m = {{9{be[1]}}, {9{be[0]}}};
      cmd_op[p] = op;
      cmd_addr[p] = a;
      cmd_wdata[p] = d;
      cmd_be[p] = be;
      cmd_valid[p] = 1'b1;
      @(negedge i_clk_sys);
      cmd_valid[p] = 1'b0;
      if (op == DPR_OP_WRITE) begin
         shadow[a] = (shadow[a] & ~m) | (d & m);
      end
      @(negedge i_clk_sys);
   endtask

   task automatic rd(input int p, input logic [AW-1:0] a, input logic [1:0] be);
      logic [DW-1:0] m;
      m = {{9{be[1]}}, {9{be[0]}}};
      cmd(p, DPR_OP_READ, a, '0, be);
      @(negedge i_clk_sys);
      chk(rd_valid[p], 1'b1);
      chk(rd_data[p] & m, shadow[a] & m);
   endtask

   task automatic wait_ready();
      for (int n = 0; n < 20 && cmd_ready !== 1'b1; n++) @(negedge i_clk_sys);
      chk(cmd_ready, 1'b1);
      chk(dpr_if_inst.ready, 2'h3);
      chk(dpr_if_inst.align_loop_en, 2'h0);
      chk(dpr_if_inst.slow_clock_select, 2'h3);
   endtask

   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         final_report();
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Mailbox steps: port, write, address, lanes, expected {right, left} flags
   int mp[8] = '{0, 0, 0, 1, 1, 1, 1, 0};
   logic mw[8] = '{1, 0, 1, 0, 0, 1, 1, 0};
   logic [AW-1:0] ma[8] = '{6'h3F, 6'h3F, 6'h3E, 6'h3F, 6'h3F, 6'h3E, 6'h3E, 6'h3E};
   logic [1:0] mb[8] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 2'h2, 2'h1};
   logic [1:0] mf[8] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h3};

   initial begin
      repeat (6) @(negedge i_clk_sys);
      i_rst = 1'b0;
      @(negedge i_clk_sys);
      chk(dpr_if_inst.ready, 2'h0);
      chk(mbx_flag_n, 2'h3);
      chk(wrap_flag_n, 2'h3);
      wait_ready();
      chk(cnt_value, 12'h000);
      chk(mask_value, 12'hFFF);
      cmd(0, DPR_OP_WRITE, 6'h05, 18'h3FFFF, 2'h3);
      cmd(0, DPR_OP_WRITE, 6'h05, 18'h00000, 2'h1);
      rd(1, 6'h05, 2'h3);
      fork
         cmd(0, DPR_OP_WRITE, 6'h06, 18'h1234A, 2'h3);
         cmd(1, DPR_OP_WRITE, 6'h07, 18'h2BCD5, 2'h3);
      join
      rd(1, 6'h06, 2'h3);
      rd(0, 6'h07, 2'h3);
      for (int i = 0; i < 8; i++) begin
         if (mw[i]) begin
            cmd(mp[i], DPR_OP_WRITE, ma[i], 18'h2A5A5 ^ 18'(i), mb[i]);
         end else begin
            rd(mp[i], ma[i], mb[i]);
         end
         @(negedge i_clk_sys);
         chk(mbx_flag_n, mf[i]);
      end
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 2; m++) begin
            wrap_mode[p] = m[0];
            cmd(p, DPR_OP_MASK_LOAD, 6'h03, '0, 2'h3);
            chk(mask_value[p], 6'h03);
            cmd(p, DPR_OP_READ, 6'h11, '0, 2'h3);
            cmd(p, DPR_OP_READ_NEXT, '0, '0, 2'h3);
            cmd(p, DPR_OP_WRITE_NEXT, '0, '0, 2'h0);
            chk(cnt_value[p], 6'h13);
            chk(dpr_if_inst.counter_wrap_flag_n[p], 1'b0);
            @(negedge i_clk_sys);
            chk(wrap_flag_n[p], 1'b0);
            cmd(p, DPR_OP_READ_NEXT, '0, '0, 2'h3);
            chk(cnt_value[p], m ? 6'h11 : 6'h10);
            chk(dpr_if_inst.counter_wrap_flag_n[p], 1'b1);
         end
      end
      cmd(0, DPR_OP_CNT_RESET, '0, '0, 2'h3);
      chk(cnt_value[0], 6'h10);
      cmd(0, DPR_OP_MASK_RESET, '0, '0, 2'h3);
      chk(mask_value[0], 6'h3F);
      cmd(1, DPR_OP_NOP, '0, '0, 2'h3);
      chk(cnt_value[1], 6'h11);
      cmd(0, DPR_OP_WRITE, 6'h3F, 18'h0F0F0, 2'h3);
      @(negedge i_clk_sys);
      chk(mbx_flag_n, 2'h1);
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      i_rst = 1'b0;
      wait_ready();
      chk(dpr_if_inst.mailbox_flag_n, 2'h3);
      chk(wrap_flag_n, 2'h3);
      chk(cnt_value, 12'h000);
      chk(mask_value, 12'hFFF);
      final_report();
   end
endmodule // tb_dual_port_ram_port_control
